/* File: tcp_pkg.sv */
// package for the test control packet decoder: register map, bit positions, carriers
package tcp_pkg;
    // register map (byte addresses on the apb slave)
    localparam logic [11:0] STIM_PACKET_OFFSET = 12'h000;
    localparam logic [11:0] CORE_CTRL_OFFSET = 12'h004;
    localparam logic [11:0] MODE_STATUS_OFFSET = 12'h008;
    localparam logic [31:0] STIM_PACKET_RESET = 32'h0000_0000;
    // core control register: bit 0 memory clock gate, bit 1 internal data bus enable
    localparam int CTRL_MCLK_GATE_BIT = 0;
    localparam int CTRL_INT_DBE_BIT = 1;
    localparam logic [1:0] CORE_CTRL_RESET = 2'h0;
    // packet bit positions
    localparam int CORE_TEST_BIT = 31;
    localparam int TAG_TEST_BIT = 30;
    localparam int RAM_TEST_BIT = 29;
    localparam int FORCE_FAST_CLOCK_BIT = 28;
    localparam int MMU_TEST_BIT = 27;
    localparam int BL_HI_BIT = 24;
    localparam int BL_LO_BIT = 21;
    localparam int TMS_BIT = 20;
    localparam int TDI_BIT = 19;
    localparam int TCK_BIT = 18;
    localparam int TRST_BIT = 17;
    localparam int EXT1_BIT = 16;
    localparam int EXT0_BIT = 15;
    localparam int OS_MMU_BIT = 10;
    localparam int ABE_BIT = 7;
    localparam int DBE_BIT = 5;
    localparam int FIQ_BIT = 4;
    localparam int IRQ_BIT = 3;
    localparam int ABORT_BIT = 2;
    localparam int WAIT_BIT = 1;
    localparam int RESET_BIT = 0;

    // active test mode
    typedef enum logic [2:0] {
        TCP_MODE_NORMAL,
        TCP_MODE_CORE,
        TCP_MODE_TAG,
        TCP_MODE_RAM,
        TCP_MODE_MMU
    } tcp_mode_e;

    // signals driven to the processor core
    typedef struct packed {
        logic debug_port_mode_select;
        logic debug_port_serial_in;
        logic debug_port_clock;
        logic debug_port_reset_n;
        logic watch_input_one;
        logic watch_input_zero;
        logic os_mmu_enhance_enable;
        logic fast_irq_n;
        logic normal_irq_n;
        logic memory_abort;
        logic stall_request_n;
        logic core_reset_n;
        logic [3:0] byte_latch_controls;
        logic scan_serial_out_input;
        logic address_bus_drive_enable;
        logic data_bus_drive_enable;
    } tcp_core_in_s;

    // test mode selects
    typedef struct packed {
        logic core_test_enable;
        logic tag_array_test_enable;
        logic cache_ram_test_enable;
        logic translation_test_enable;
        logic fast_clock_select_override;
        logic rest_held_in_reset;
    } tcp_mode_sel_s;
endpackage

/* File: tcp_decoder.sv */
// test control packet decoder with apb register access
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - packet bit 31 selects whole-core test; low bits then drive core inputs
// - packet bit 30 enables cache tag array test mode
// - packet bit 29 enables cache data ram test mode
// - packet bit 27 enables translation buffer test mode
// - in whole-core test bit 27 drives the scan serial out input instead
// - bits 20..17 drive debug mode select, serial in, clock, reset_n
// - bits 16 and 15 drive watchpoint inputs one then zero
// - bit 10 drives the os memory management enhancement enable
// - bits 4..0 drive fiq_n, irq_n, abort, stall_n, reset_n
// - core test: byte latch bits anded with memory clock gate
// - core test: test clock bit anded with memory clock gate and bus clock
// - core test: wait bit anded with memory clock gate
// - core test: data bus enable anded with internal enable and bus clock
// - tag or translation test holds rest of processor in reset
module tcp_decoder (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system bus clock sampled as a level
    input wire logic bus_clock,
    // core-side outputs
    output tcp_pkg::tcp_core_in_s core_in,
    output tcp_pkg::tcp_mode_sel_s mode_sel
);
    logic [31:0] packet_q;
    logic [1:0] ctrl_q;
    logic [31:0] rdata_q;
    logic slverr_q;
    tcp_pkg::tcp_mode_e mode;
    tcp_pkg::tcp_core_in_s core_d;
    tcp_pkg::tcp_mode_sel_s sel_d;
    logic wr_en;
    logic rd_en;

    // address decode used for both reads and writes
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == tcp_pkg::STIM_PACKET_OFFSET) || (a == tcp_pkg::CORE_CTRL_OFFSET) ||
                    (a == tcp_pkg::MODE_STATUS_OFFSET);
    endfunction

    // zero wait state slave: the access phase always completes
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign prdata = rdata_q;
    assign pslverr = slverr_q;

    // packet register, byte lanes honoured; status register is read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            packet_q <= tcp_pkg::STIM_PACKET_RESET;
        end else if (wr_en && paddr == tcp_pkg::STIM_PACKET_OFFSET) begin
            for (int i = 0; i < 4; i++) begin
                if (pstrb[i]) begin
                    packet_q[i*8 +: 8] <= pwdata[i*8 +: 8];
                end
            end
        end
    end

    // core control register: memory clock gate and internal data bus enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= tcp_pkg::CORE_CTRL_RESET;
        end else if (wr_en && paddr == tcp_pkg::CORE_CTRL_OFFSET && pstrb[0]) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // read data registered one cycle ahead would lag, so prdata is taken in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                tcp_pkg::CORE_CTRL_OFFSET: rdata_q <= {30'h0, ctrl_q};
                tcp_pkg::MODE_STATUS_OFFSET: rdata_q <= {26'h0, sel_d};
                default: rdata_q <= 32'h0000_0000; // packet is write only
            endcase
        end
    end

    // unmapped address answers with an error in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slverr_q <= 1'b0;
        end else if (psel && !penable) begin
            slverr_q <= !is_mapped(paddr);
        end else begin
            slverr_q <= 1'b0;
        end
    end

    // mode decode; core test outranks the array tests
    always_comb begin
        if (packet_q[tcp_pkg::CORE_TEST_BIT]) begin
            mode = tcp_pkg::TCP_MODE_CORE;
        end else if (packet_q[tcp_pkg::TAG_TEST_BIT]) begin
            mode = tcp_pkg::TCP_MODE_TAG;
        end else if (packet_q[tcp_pkg::RAM_TEST_BIT]) begin
            mode = tcp_pkg::TCP_MODE_RAM;
        end else if (packet_q[tcp_pkg::MMU_TEST_BIT]) begin
            mode = tcp_pkg::TCP_MODE_MMU;
        end else begin
            mode = tcp_pkg::TCP_MODE_NORMAL;
        end
    end

    // next values of the mode selects
    always_comb begin
        sel_d = '0;
        sel_d.fast_clock_select_override = packet_q[tcp_pkg::FORCE_FAST_CLOCK_BIT];
        case (mode)
            tcp_pkg::TCP_MODE_CORE: sel_d.core_test_enable = 1'b1;
            tcp_pkg::TCP_MODE_TAG: begin
                sel_d.tag_array_test_enable = 1'b1;
                sel_d.rest_held_in_reset = 1'b1;
            end
            tcp_pkg::TCP_MODE_RAM: sel_d.cache_ram_test_enable = 1'b1;
            tcp_pkg::TCP_MODE_MMU: begin
                sel_d.translation_test_enable = 1'b1;
                sel_d.rest_held_in_reset = 1'b1;
            end
            default: ; // normal mode keeps the cleared selects
        endcase
    end

    // next values of the core inputs; unused bits are simply never read
    always_comb begin
        core_d = '0;
        core_d.debug_port_reset_n = 1'b1;
        core_d.fast_irq_n = 1'b1;
        core_d.normal_irq_n = 1'b1;
        core_d.stall_request_n = 1'b1;
        core_d.core_reset_n = 1'b1;
        core_d.address_bus_drive_enable = 1'b1;
        core_d.debug_port_mode_select = packet_q[tcp_pkg::TMS_BIT];
        core_d.debug_port_serial_in = packet_q[tcp_pkg::TDI_BIT];
        core_d.debug_port_clock = packet_q[tcp_pkg::TCK_BIT];
        core_d.debug_port_reset_n = packet_q[tcp_pkg::TRST_BIT];
        core_d.watch_input_one = packet_q[tcp_pkg::EXT1_BIT];
        core_d.watch_input_zero = packet_q[tcp_pkg::EXT0_BIT];
        core_d.os_mmu_enhance_enable = packet_q[tcp_pkg::OS_MMU_BIT];
        core_d.fast_irq_n = packet_q[tcp_pkg::FIQ_BIT];
        core_d.normal_irq_n = packet_q[tcp_pkg::IRQ_BIT];
        core_d.memory_abort = packet_q[tcp_pkg::ABORT_BIT];
        core_d.stall_request_n = packet_q[tcp_pkg::WAIT_BIT];
        core_d.core_reset_n = packet_q[tcp_pkg::RESET_BIT];
        if (mode == tcp_pkg::TCP_MODE_CORE) begin
            // gating keeps core state changes inside the data access cycle
            core_d.byte_latch_controls = packet_q[tcp_pkg::BL_HI_BIT:tcp_pkg::BL_LO_BIT]
                                         & {4{ctrl_q[tcp_pkg::CTRL_MCLK_GATE_BIT]}};
            core_d.debug_port_clock = packet_q[tcp_pkg::TCK_BIT] & ctrl_q[tcp_pkg::CTRL_MCLK_GATE_BIT]
                                      & bus_clock;
            core_d.stall_request_n = packet_q[tcp_pkg::WAIT_BIT]
                                     & ctrl_q[tcp_pkg::CTRL_MCLK_GATE_BIT];
            core_d.data_bus_drive_enable = packet_q[tcp_pkg::DBE_BIT] & ctrl_q[tcp_pkg::CTRL_INT_DBE_BIT]
                                           & bus_clock;
            core_d.scan_serial_out_input = packet_q[tcp_pkg::MMU_TEST_BIT];
            // tristating the address bus hides address values from readback
            core_d.address_bus_drive_enable = packet_q[tcp_pkg::ABE_BIT];
        end
        if (sel_d.rest_held_in_reset) begin
            core_d.core_reset_n = 1'b0;
        end
        // remaining packet bits have no destination in any mode
    end

    // outputs from flip-flops, so they lag the packet write by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_in <= '{debug_port_reset_n: 1'b0, core_reset_n: 1'b0, fast_irq_n: 1'b1,
                         normal_irq_n: 1'b1, stall_request_n: 1'b1, default: 1'b0};
            mode_sel <= '0;
        end else begin
            core_in <= core_d;
            mode_sel <= sel_d;
        end
    end
endmodule // tcp_decoder
`default_nettype wire

/* File: tcp_ctl_model.sv */
// apb master model standing in for the external test controller
`timescale 1ns/1ps
`default_nettype none
module tcp_ctl_model (
    // clock
    input wire logic pclk,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int hung = 0;
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    // one transfer; a slave that never answers is cut off after 16 edges
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            if (n == 15) hung++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data shows no stale value
    endtask
endmodule // tcp_ctl_model
`default_nettype wire

/* File: tcp_decoder_properties.sv */
// assertion checker for the test control packet decoder
`timescale 1ns/1ps
`default_nettype none
module tcp_decoder_properties (
    // apb side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    // core side
    input wire logic bus_clock,
    input wire tcp_pkg::tcp_core_in_s core_in,
    input wire tcp_pkg::tcp_mode_sel_s mode_sel
);
    logic [31:0] p_q;
    logic [1:0] c_q;
    logic up_q;
    logic wr;
    logic k;
    logic h;
    assign wr = psel && penable && pwrite && pready;
    assign k = p_q[31];
    assign h = !k && (p_q[30] || !p_q[29] && p_q[27]);
    // shadow of packet and control words, lane by lane
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_q <= 32'h0000_0000;
            c_q <= 2'h0;
            up_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
            for (int i = 0; i < 4; i++) begin
                if (wr && paddr == 12'h000 && pstrb[i]) p_q[8*i +: 8] <= pwdata[8*i +: 8];
            end
            if (wr && paddr == 12'h004 && pstrb[0]) c_q <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // outputs are registered, so each check looks one edge back
    a_mode_decode: assert property (up_q |-> mode_sel[5:2] == $past({k, !k && p_q[30],
        p_q[31:29] == 3'b001, p_q[31:29] == 3'b000 && p_q[27]})) else $error("mode decode wrong");
    a_scan_route: assert property (up_q |-> core_in[2] == $past(k && p_q[27])) else $error("scan route");
    a_debug_pins: assert property (up_q |-> {core_in[18:17], core_in[15]} == $past({p_q[20:19], p_q[17]}))
        else $error("debug pins wrong");
    a_side_pins: assert property (up_q |-> core_in[14:9] == $past({p_q[16:15], p_q[10], p_q[4:2]}))
        else $error("side pins wrong");
    a_latch_gate: assert property (up_q |-> core_in[6:3] == $past(k ? p_q[24:21] & {4{c_q[0]}} : 4'h0))
        else $error("latch gating wrong");
    a_clock_gate: assert property (up_q |-> core_in[16] == $past(p_q[18] && (!k || c_q[0] && bus_clock)))
        else $error("test clock gating wrong");
    a_stall_gate: assert property (up_q && $past(k && !c_q[0]) |-> !core_in[8]) else $error("stall not gated");
    a_dbe_gate: assert property (up_q |-> core_in[0] == $past(k && p_q[5] && c_q[1] && bus_clock))
        else $error("data enable gating wrong");
    a_hold_reset: assert property (up_q && $past(h) |-> mode_sel[0] && !core_in[7]) else $error("rest not held");
    c_core_dbe: cover property (mode_sel[5] && core_in[0]);
    c_tag: cover property (mode_sel[4]);
    c_mmu: cover property (mode_sel[2]);
    c_ram: cover property (mode_sel[3]);
endmodule // tcp_decoder_properties
bind tcp_decoder tcp_decoder_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .bus_clock, .core_in, .mode_sel);
`default_nettype wire

/* File: tb.sv */
// self-checking testbench for the test control packet decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic bus_clock = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] pk = 32'h0;
    logic [3:0] pstrb;
    logic [1:0] cr = 2'h0;
    tcp_pkg::tcp_core_in_s core_in;
    tcp_pkg::tcp_mode_sel_s mode_sel;
    int n_mismatch = 0;
    int check_count = 0;
    always #10 pclk = ~pclk;
    tcp_ctl_model CTL (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
    tcp_decoder DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .bus_clock, .core_in, .mode_sel);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // expected core pins for packet p, gate g, internal data enable i, bus clock b
    function automatic logic [18:0] e_core(logic [31:0] p, logic g, logic i, logic b);
        logic c;
        logic h;
        c = p[31];
        h = !c && (p[30] || !p[29] && p[27]);
        return {p[20:19], c ? p[18] & g & b : p[18], p[17:15], p[10], p[4:2], c ? p[1] & g : p[1],
            p[0] & !h, c ? p[24:21] & {4{g}} : 4'h0, c & p[27], !c | p[7], c & p[5] & i & b};
    endfunction
    function automatic logic [5:0] e_mode(logic [31:0] p);
        return {p[31], !p[31] & p[30], p[31:29] == 3'b001, (p[31:29] == 3'b000) & p[27], p[28],
            !p[31] & (p[30] | !p[29] & p[27])};
    endfunction
    // one transfer; a slave that hangs ends the run at once
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        CTL.xfer(w, a, d, s, rd, er);
        if (CTL.hung != 0) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input logic e);
        bus(1'b0, a, 32'h0, 4'h0);
        chk(rd, x);
        chk({31'h0, er}, {31'h0, e});
    endtask
    // write, then give the registered outputs two edges to land
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, a, d, s);
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic look();
        chk({13'h0, core_in}, {13'h0, e_core(pk, cr[0], cr[1], bus_clock)});
        chk({26'h0, mode_sel}, {26'h0, e_mode(pk)});
    endtask
    task automatic pkt(input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) pk[8*i +: 8] = d[8*i +: 8];
        end
        wr(12'h000, d, s);
        look();
    endtask
    task automatic t_reset();
        repeat (2) @(posedge pclk);
        #1;
        look();
        rdchk(12'h000, 32'h0, 1'b0);
    endtask
    // one packet bit at a time, assigned and unassigned alike
    task automatic t_walk();
        for (int b = 0; b < 32; b++) begin
            pkt(32'h1 << b, 4'hf);
        end
    endtask
    // mode entries and priority clashes, seen on the pins and in the status word
    task automatic t_modes();
        logic [31:0] tbl [5] = '{32'hd000_0000, 32'h5000_0001, 32'h1800_0001, 32'h6800_0001, 32'h2800_0001};
        foreach (tbl[j]) begin
            pkt(tbl[j], 4'hf);
            rdchk(12'h008, {26'h0, e_mode(pk)}, 1'b0);
        end
    endtask
    // whole-core test under every gate and bus clock combination
    task automatic t_core();
        for (int v = 0; v < 8; v++) begin
            @(posedge pclk);
            bus_clock <= v[2];
            cr = v[1:0];
            wr(12'h004, 32'(v), 4'h1);
            rdchk(12'h004, {30'h0, cr}, 1'b0);
            pkt(32'h89e4_00a3, 4'hf);
        end
    endtask
    // refused places and a single-lane packet write
    task automatic t_refuse();
        wr(12'h008, 32'hffff_ffff, 4'hf);
        look();
        rdchk(12'h00c, 32'h0, 1'b1);
        pkt(32'hffff_ffff, 4'h2);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_walk();
        t_modes();
        t_core();
        t_refuse();
        print_verdict();
    end
    // cut a hang short well inside the cycle budget
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
endmodule // tb
`default_nettype wire
